// File: hdl/bsw_pkg.sv
// Shared constants and types of the stopwatch timer
`default_nettype none
package bsw_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int INDEX_W = 16;
    // ----------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------
    localparam logic [INDEX_W-1:0] PRIO_INDEX = 16'hff20;
    localparam logic [INDEX_W-1:0] ENABLE_INDEX = 16'hff22;
    localparam logic [INDEX_W-1:0] FLAG_INDEX = 16'hff24;
    localparam logic [INDEX_W-1:0] DIGIT_INDEX = 16'hff44;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int HUND_BIT = 6;
    localparam int TENTH_BIT = 5;
    localparam int SEC_BIT = 4;
    localparam int EVT_LSB = 4;
    localparam int PRIO_LSB = 2;
    localparam int HUND_LSB = 0;
    localparam int TENTH_LSB = 4;
    localparam logic [REG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [3:0] DIGIT_RESET = 4'h0;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    // ----------------------------------------
    // Timing: ticks per second and count pulses per second
    // ----------------------------------------
    localparam int TICK_HZ = 256;
    localparam int HUND_HZ = 100;
    localparam logic [8:0] ACC_WRAP = 9'(TICK_HZ);
    localparam logic [8:0] ACC_STEP = 9'(HUND_HZ);
    // ----------------------------------------
    // Exception vectors
    // ----------------------------------------
    localparam logic [23:0] VEC_HUND = 24'h000016;
    localparam logic [23:0] VEC_TENTH = 24'h000018;
    localparam logic [23:0] VEC_SEC = 24'h00001a;
    // Event order matches bits 6..4 of flag and enable registers
    typedef struct packed {
        logic hund;
        logic tenth;
        logic sec;
    } bsw_evt_t;
endpackage
`default_nettype wire

// File: hdl/bsw_divider.sv
// Tick synchroniser and feedback divider to the approximate 100 Hz pulse
`default_nettype none
module bsw_divider
    import bsw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick from the low-speed oscillator domain
    input wire logic low_speed_osc_clock,
    // Events
    output logic tick,
    output logic pulse
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic [8:0] acc;
    logic [8:0] sum;
    logic [8:0] next_acc;

    // Falling edge of the 256 Hz signal, after two stages
    assign tick = sync3 & ~sync2;
    assign sum = acc + ACC_STEP;
    // Accumulating 100/256 per tick gives gaps of 2 or 3 ticks
    assign pulse = tick && (sum >= ACC_WRAP);
    assign next_acc = !tick ? acc : (pulse ? 9'(sum - ACC_WRAP) : sum);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            acc <= 9'h000;
        end else begin
            sync1 <= low_speed_osc_clock;
            sync2 <= sync1;
            sync3 <= sync2;
            acc <= next_acc;
        end
    end
endmodule
`default_nettype wire

// File: hdl/bsw_bcd_digit.sv
// One 4-bit BCD counting stage with carry out
`default_nettype none
module bsw_bcd_digit
    import bsw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Count
    input wire logic inc,
    output logic [3:0] digit,
    output logic carry
);
    logic [3:0] next_digit;

    assign carry = inc && (digit == DIGIT_MAX);
    assign next_digit = !inc ? digit : (carry ? DIGIT_RESET : 4'(digit + 4'h1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digit <= DIGIT_RESET;
        end else begin
            digit <= next_digit;
        end
    end
endmodule
`default_nettype wire

// File: hdl/bsw_top.sv
// Stopwatch timer: divider, two BCD digits, flags and interrupt request
`default_nettype none
module bsw_top
    import bsw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [bsw_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bsw_pkg::DATA_W-1:0] pwdata,
    output logic [bsw_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // 256 Hz tick from the low-speed oscillator
    input wire logic low_speed_osc_clock,
    // CPU interrupt mask level
    input wire logic cpu_mask_level_low,
    input wire logic cpu_mask_level_high,
    // Interrupt request to the CPU
    output logic irq,
    output logic [1:0] irq_level,
    output logic [23:0] irq_vector
);
    // ----------------------------------------
    // Counting chain
    // ----------------------------------------
    logic tick;
    logic hund_pulse;
    logic [3:0] hundredths_digit;
    logic [3:0] tenths_digit;
    logic tenth_carry;
    logic sec_carry;
    bsw_evt_t evt;

    bsw_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .low_speed_osc_clock(low_speed_osc_clock),
        .tick(tick),
        .pulse(hund_pulse)
    );

    bsw_bcd_digit u_hund (
        .pclk(pclk),
        .presetn(presetn),
        .inc(hund_pulse),
        .digit(hundredths_digit),
        .carry(tenth_carry)
    );

    // Tenths stage advances on the hundredths carry
    bsw_bcd_digit u_tenth (
        .pclk(pclk),
        .presetn(presetn),
        .inc(tenth_carry),
        .digit(tenths_digit),
        .carry(sec_carry)
    );

    // Each event marks the falling edge of its rate signal
    assign evt = '{hund: hund_pulse, tenth: tenth_carry, sec: sec_carry};

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    bsw_evt_t flags;
    bsw_evt_t enables;
    bsw_evt_t next_flags;
    logic [1:0] prio;
    logic [1:0] cpu_mask;
    logic [INDEX_W-1:0] index;
    logic hit_prio;
    logic hit_enable;
    logic hit_flag;
    logic hit_digit;
    logic mapped;
    logic setup;
    logic commit;
    logic wr_commit;
    bsw_evt_t clear_req;
    logic [REG_W-1:0] rd_byte;

    assign cpu_mask = {cpu_mask_level_high, cpu_mask_level_low};
    assign index = paddr[ADDR_W-1:2];
    assign hit_prio = (index == PRIO_INDEX);
    assign hit_enable = (index == ENABLE_INDEX);
    assign hit_flag = (index == FLAG_INDEX);
    assign hit_digit = (index == DIGIT_INDEX);
    assign mapped = hit_prio | hit_enable | hit_flag | hit_digit;
    assign setup = psel & ~penable;
    assign commit = psel & penable & pready;
    assign wr_commit = commit & pwrite & mapped;

    // Only ones in the written byte clear; zeros leave flags alone
    assign clear_req = (wr_commit && hit_flag) ? bsw_evt_t'(pwdata[HUND_BIT:SEC_BIT]) : '0;

    // Set wins over a clear in the same cycle, so no event is lost
    generate
        for (genvar i = 0; i < 3; i++) begin : g_flag
            assign next_flags[i] = (flags[i] & ~clear_req[i]) | evt[i];
        end
    endgenerate

    // Read mux: reserved bits read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit_prio) begin
            rd_byte[PRIO_LSB+1:PRIO_LSB] = prio;
        end else if (hit_enable) begin
            rd_byte[HUND_BIT:SEC_BIT] = enables;
        end else if (hit_flag) begin
            rd_byte[HUND_BIT:SEC_BIT] = flags;
        end else if (hit_digit) begin
            rd_byte = {tenths_digit, hundredths_digit};
        end
    end

    // Answer is ready in the first access cycle; no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? {24'h000000, rd_byte} : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAG_RESET[HUND_BIT:SEC_BIT];
            enables <= ENABLE_RESET[HUND_BIT:SEC_BIT];
            prio <= PRIO_RESET;
        end else begin
            flags <= next_flags;
            if (wr_commit && hit_enable) begin
                enables <= bsw_evt_t'(pwdata[HUND_BIT:SEC_BIT]);
            end
            if (wr_commit && hit_prio) begin
                prio <= pwdata[PRIO_LSB+1:PRIO_LSB];
            end
        end
    end

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    bsw_evt_t pending;
    logic any_req;
    logic [23:0] next_vector;

    // Flags set regardless; only the request is gated
    assign pending = flags & enables;
    // Level zero is never above any mask, so it never interrupts
    assign any_req = (|pending) && (prio > cpu_mask);
    // Fastest rate has the lowest vector and is served first
    assign next_vector = pending.hund ? VEC_HUND : (pending.tenth ? VEC_TENTH : VEC_SEC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            irq_level <= 2'h0;
            irq_vector <= 24'h000000;
        end else begin
            irq <= any_req;
            irq_level <= prio;
            irq_vector <= next_vector;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [2:0] gap_hund;
    logic [5:0] gap_tenth;
    logic [8:0] gap_sec;

    // Tick counts since the last event of each rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_hund <= 3'h0;
            gap_tenth <= 6'h00;
            gap_sec <= 9'h000;
        end else begin
            if (hund_pulse) begin
                gap_hund <= 3'h0;
            end else if (tick && gap_hund != 3'h7) begin
                gap_hund <= 3'(gap_hund + 3'h1);
            end
            if (tenth_carry) begin
                gap_tenth <= 6'h00;
            end else if (tick && gap_tenth != 6'h3f) begin
                gap_tenth <= 6'(gap_tenth + 6'h1);
            end
            if (sec_carry) begin
                gap_sec <= 9'h000;
            end else if (tick && gap_sec != 9'h1ff) begin
                gap_sec <= 9'(gap_sec + 9'h1);
            end
        end
    end

    property p_digit_range;
        @(posedge pclk) disable iff (!presetn)
        hundredths_digit <= DIGIT_MAX && tenths_digit <= DIGIT_MAX;
    endproperty
    a_digit_range: assert property (p_digit_range) else $error("BCD digit out of range");

    property p_hund_gap;
        @(posedge pclk) disable iff (!presetn)
        hund_pulse |-> (gap_hund == 3'h1 || gap_hund == 3'h2);
    endproperty
    a_hund_gap: assert property (p_hund_gap) else $error("Count pulse gap not 2 or 3 ticks");

    property p_tenth_gap;
        @(posedge pclk) disable iff (!presetn)
        tenth_carry |-> (gap_tenth == 6'd24 || gap_tenth == 6'd25);
    endproperty
    a_tenth_gap: assert property (p_tenth_gap) else $error("Tenths carry gap not 25 or 26 ticks");

    property p_sec_gap;
        @(posedge pclk) disable iff (!presetn)
        sec_carry |-> gap_sec == 9'd255 && tenths_digit == DIGIT_MAX;
    endproperty
    a_sec_gap: assert property (p_sec_gap) else $error("Seconds carry not 256 ticks apart");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        (evt.tenth || evt.sec) |=> (flags.tenth || !$past(evt.tenth)) && (flags.sec || !$past(evt.sec));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Tenths or seconds flag not set");

    property p_hund_flag;
        @(posedge pclk) disable iff (!presetn)
        evt.hund |=> flags.hund;
    endproperty
    a_hund_flag: assert property (p_hund_flag) else $error("Hundredths flag not set");

    property p_sec_flag_any_enable;
        @(posedge pclk) disable iff (!presetn)
        (evt.sec && !enables.sec) |=> flags.sec && !$past(pending.sec);
    endproperty
    a_sec_flag_any_enable: assert property (p_sec_flag_any_enable) else $error("Seconds flag gated");

    property p_clear_one;
        @(posedge pclk) disable iff (!presetn)
        (wr_commit && hit_flag && pwdata[TENTH_BIT] && !evt.tenth) |=> !flags.tenth;
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("Write of one did not clear flag");

    property p_zero_keeps;
        @(posedge pclk) disable iff (!presetn)
        (flags.hund && !(wr_commit && hit_flag && pwdata[HUND_BIT])) |=> flags.hund;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("Flag lost without a clear");

    property p_level_zero;
        @(posedge pclk) disable iff (!presetn)
        (prio == 2'h0)[*2] |-> !irq;
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("Interrupt at priority level 0");

    property p_irq_cause;
        @(posedge pclk) disable iff (!presetn)
        irq |-> $past(pending) != 3'h0 && $past(prio) > $past(cpu_mask) && irq_level == $past(prio);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("Request without enabled flag or level");

    property p_enable_off;
        @(posedge pclk) disable iff (!presetn)
        (enables == 3'h0) [*2] |-> !irq;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("Request while all enables clear");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        (irq && $past(pending.hund)) |-> irq_vector == VEC_HUND;
    endproperty
    a_vector: assert property (p_vector) else $error("Wrong vector for hundredths request");

    property p_sec_vector;
        @(posedge pclk) disable iff (!presetn)
        (irq && $past(pending) == 3'h1) |-> irq_vector == VEC_SEC;
    endproperty
    a_sec_vector: assert property (p_sec_vector) else $error("Wrong vector for seconds request");

    property p_digit_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && hit_digit) |=> prdata[7:0] == {$past(tenths_digit), $past(hundredths_digit)} && pready;
    endproperty
    a_digit_read: assert property (p_digit_read) else $error("Digit read mismatch");
endmodule
`default_nettype wire

// File: test/bsw_osc_model.sv
// Slow oscillator model: one 256 Hz tick period per request
`default_nettype none
module bsw_osc_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick request from the bench
    input wire logic tick_req,
    output logic tick_done,
    // Oscillator output to the block
    output logic low_speed_osc_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half period shortened from the real 256 Hz; the block only sees edges
    localparam int HALF = 8;
    initial begin
        low_speed_osc_clock = 1'b1;
        tick_done = 1'b0;
        forever begin
            @(posedge pclk);
            tick_done <= 1'b0;
            if (presetn && tick_req) begin
                // Falling edge marks the tick; clock stands high between ticks
                low_speed_osc_clock <= 1'b0;
                repeat (HALF) @(posedge pclk);
                low_speed_osc_clock <= 1'b1;
                repeat (HALF) @(posedge pclk);
                tick_done <= 1'b1;
                @(posedge pclk);
                tick_done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/tb_bcd_stopwatch_timer.sv
// Self-checking bench of the stopwatch timer
`default_nettype none
module tb_bcd_stopwatch_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import bsw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, tick_req, tick_done, osc;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic pready, pslverr, irq;
    logic [1:0] mask, irq_level;
    logic [23:0] irq_vector;
    int bad_count = 0;
    int comparisons = 0;
    int ticks = 0;

    bsw_top u_bsw_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_speed_osc_clock(osc), .cpu_mask_level_low(mask[0]), .cpu_mask_level_high(mask[1]),
        .irq(irq), .irq_level(irq_level), .irq_vector(irq_vector));
    bsw_osc_model u_bsw_osc_model (.pclk(pclk), .presetn(presetn), .tick_req(tick_req),
        .tick_done(tick_done), .low_speed_osc_clock(osc));

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) check_word(32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_check(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, rd, err);
        check_word(rd, exp);
        check_word({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
    endtask

    task automatic do_ticks(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge pclk);
            tick_req <= 1'b1;
            @(posedge pclk);
            tick_req <= 1'b0;
            while (tick_done !== 1'b1) @(posedge pclk);
            ticks++;
        end
    endtask

    // Expected digits from the 100 per 256 accumulator
    function automatic logic [31:0] exp_digits(input int n);
        int p;
        p = ((100 * n) / 256) % 100;
        return 32'((p / 10) * 16 + (p % 10));
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_and_map();
        rd_check(PRIO_INDEX, 32'h0, 1'b0);
        rd_check(ENABLE_INDEX, 32'h0, 1'b0);
        rd_check(FLAG_INDEX, 32'h0, 1'b0);
        rd_check(DIGIT_INDEX, 32'h0, 1'b0);
        rd_check(16'h0001, 32'h0, 1'b1);
        wr(ENABLE_INDEX, 32'hffff_ffff);
        rd_check(ENABLE_INDEX, 32'h70, 1'b0);
        wr(ENABLE_INDEX, 32'h0);
        wr(PRIO_INDEX, 32'hff);
        rd_check(PRIO_INDEX, 32'h0c, 1'b0);
        wr(DIGIT_INDEX, 32'h99);
        rd_check(DIGIT_INDEX, 32'h0, 1'b0);
    endtask

    task automatic t_count();
        int i;
        // Single steps expose the 2/3 tick spacing and first carry
        for (i = 1; i <= 30; i++) begin
            do_ticks(1);
            rd_check(DIGIT_INDEX, exp_digits(ticks), 1'b0);
            if (ticks == 2) rd_check(FLAG_INDEX, 32'h00, 1'b0);
            if (ticks == 3) rd_check(FLAG_INDEX, 32'h40, 1'b0);
            if (ticks == 25) rd_check(FLAG_INDEX, 32'h40, 1'b0);
            if (ticks == 26) rd_check(FLAG_INDEX, 32'h60, 1'b0);
        end
        do_ticks(255 - ticks);
        rd_check(DIGIT_INDEX, 32'h99, 1'b0);
        rd_check(FLAG_INDEX, 32'h60, 1'b0);
        do_ticks(1);
        rd_check(DIGIT_INDEX, 32'h00, 1'b0);
        rd_check(FLAG_INDEX, 32'h70, 1'b0);
    endtask

    task automatic t_vector();
        logic [7:0] en [6] = '{8'h40, 8'h20, 8'h10, 8'h30, 8'h60, 8'h00};
        logic [23:0] vec [6] = '{VEC_HUND, VEC_TENTH, VEC_SEC, VEC_TENTH, VEC_HUND, VEC_SEC};
        int i;
        wr(PRIO_INDEX, 32'h0c);
        for (i = 0; i < 6; i++) begin
            wr(ENABLE_INDEX, 32'(en[i]));
            repeat (3) @(posedge pclk);
            check_word(32'(irq_vector), 32'(vec[i]));
            check_word({31'h0, irq}, {31'h0, (en[i] != 8'h00)});
        end
    endtask

    task automatic t_priority();
        int p, m;
        wr(ENABLE_INDEX, 32'h40);
        for (p = 0; p < 4; p++) begin
            wr(PRIO_INDEX, 32'(p * 4));
            for (m = 0; m < 4; m++) begin
                @(posedge pclk);
                mask <= 2'(m);
                repeat (3) @(posedge pclk);
                check_word({31'h0, irq}, {31'h0, (p > m)});
                check_word(32'(irq_level), 32'(p));
            end
        end
        @(posedge pclk);
        mask <= 2'h0;
    endtask

    task automatic t_clear();
        wr(PRIO_INDEX, 32'h0c);
        wr(ENABLE_INDEX, 32'h70);
        wr(FLAG_INDEX, 32'h00);
        rd_check(FLAG_INDEX, 32'h70, 1'b0);
        wr(FLAG_INDEX, 32'h20);
        rd_check(FLAG_INDEX, 32'h50, 1'b0);
        wr(FLAG_INDEX, 32'h50);
        rd_check(FLAG_INDEX, 32'h00, 1'b0);
        repeat (3) @(posedge pclk);
        check_word({31'h0, irq}, 32'h0);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        tick_req = 1'b0;
        mask = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_map();
        t_count();
        t_vector();
        t_priority();
        t_clear();
        print_verdict();
    end

    // Whole run needs under 10k cycles; allow four times that
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
